// ### rtl/mdc_pkg.sv
// Constants, register map and encodings of the eight-channel memory mover
// Summary of operation
// - Eight channels, each configured alone, all may hold a transaction at once.
// - Source and destination may be any 16-bit address, register region or RAM.
// - Programmable high and low limits bound accesses above the register region.
// - An access outside the limits ends the transaction and raises a channel event.
// - Per-channel size bit picks byte or word; reset leaves word size.
// - In byte size the address LSB selects upper or lower byte lane.
// - Each channel starts on its selected trigger, independent of its addresses.
// - One-shot mode moves exactly one item per trigger.
// - Continuous mode moves back to back until the counter runs out.
// - Repeated one-shot moves one item per trigger until software disables it.
// - Repeated continuous moves a full counted series per trigger until disabled.
// - Reload restores pointers and count after completion; repeated modes always reload.
// - Fixed or block addressing chosen separately for source and destination.
// - Block pointers increment or decrement independently after each move.
// - Round-robin: lower channel wins first collision, then higher numbers in turn.
// - Fixed scheme: lowest numbered requester wins a collision unless it is the channel just served.
// - Fixed scheme: the channel just served gets no immediate retrigger grant while another channel requests.
// - A busy high-priority channel waits for the next lower pending requester.
// - The engine starts no bus access while the CPU asks for the bus; an access already begun runs on.
// - Two power-down bits gate channels 0-3 and 4-7; each stops only its own group, both together stop the engine.
// - Transfer mode codes: 11 rep. continuous, 10 continuous, 01 rep. one-shot, 00 one-shot.
// - Address mode codes: 00 fixed, 01 increment, 10 decrement, 11 reserved.
// - Size bit one selects bytes, zero selects words.
// - Clearing engine enable stops the engine and ends every active channel.
package mdc_pkg;

    // ==================================================
    // Register map (byte addresses)
    localparam logic [8:0] REG_ENGINE   = 9'h000;
    localparam logic [8:0] REG_HIGH_LIM = 9'h004;
    localparam logic [8:0] REG_LOW_LIM  = 9'h008;
    localparam logic [8:0] REG_PWRDN    = 9'h00c;
    localparam int         CH_SEL_BIT   = 8;
    localparam logic [4:0] CH_CTRL      = 5'h00;
    localparam logic [4:0] CH_INT       = 5'h04;
    localparam logic [4:0] CH_SRC       = 5'h08;
    localparam logic [4:0] CH_DST       = 5'h0c;
    localparam logic [4:0] CH_CNT       = 5'h10;

    // ==================================================
    // Field positions
    localparam int ENG_EN_BIT  = 15;
    localparam int PRIO_BIT    = 0;
    localparam int PD_LOW_BIT  = 0;
    localparam int PD_HIGH_BIT = 1;
    localparam int CHANNEL_ENABLE_BIT    = 0;
    localparam int SIZE_BIT    = 1;
    localparam int TRM_LSB     = 2;
    localparam int DAM_LSB     = 4;
    localparam int SAM_LSB     = 6;
    localparam int SWREQ_BIT   = 8;
    localparam int RELOAD_BIT  = 9;
    localparam int OVR_BIT     = 3;
    localparam int DONE_BIT    = 5;
    localparam int LOWF_BIT    = 6;
    localparam int HIGHF_BIT   = 7;
    localparam int TSEL_LSB    = 8;

    // ==================================================
    // Reset values and address regions
    localparam logic [15:0] CTRL_MASK    = 16'h02ff;
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] HIGH_LIM_RST = 16'hffff;
    localparam logic [15:0] LOW_LIM_RST  = 16'h0800;
    localparam logic [15:0] SFR_TOP      = 16'h07ff;

    // ==================================================
    // Encodings
    typedef enum logic [1:0] {
        TR_ONESHOT     = 2'h0,
        TR_REP_ONESHOT = 2'h1,
        TR_CONT        = 2'h2,
        TR_REP_CONT    = 2'h3
    } mdc_transfer_mode_field_e;

    typedef enum logic [1:0] {
        AM_FIXED = 2'h0,
        AM_INC   = 2'h1,
        AM_DEC   = 2'h2,
        AM_RSVD  = 2'h3
    } mdc_amode_e;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_READ   = 2'h1,
        ST_WRITE  = 2'h3,
        ST_UPDATE = 2'h2
    } mdc_state_e;

endpackage

// ### rtl/mdc_top.sv
// Eight-channel memory mover with Wishbone register slave and a bus master
`timescale 1ns/10ps
module mdc_top
    import mdc_pkg::*;
#(
    parameter int TRIG_W = 128
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone register slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [8:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output      logic [31:0]       wb_dat_o,
    output      logic              wb_ack_o,
    // Trigger sources and CPU bus demand
    input  wire logic [TRIG_W-1:0] trig_i,
    input  wire logic              cpu_bus_req_i,
    // Peripheral/data bus master
    output      logic              mem_req_o,
    output      logic              mem_we_o,
    output      logic [15:0]       mem_addr_o,
    output      logic [15:0]       mem_wdata_o,
    output      logic [1:0]        mem_be_o,
    input  wire logic              mem_ack_i,
    input  wire logic [15:0]       mem_rdata_i,
    // Per-channel completion or limit event
    output      logic [7:0]        chan_event_o
);

    // ==================================================
    // Helper functions
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] md, input logic byte_sz);
        logic [15:0] d;
        d = byte_sz ? 16'h0001 : 16'h0002;
        unique case (md)
            AM_INC:  step = a + d;
            AM_DEC:  step = a - d;
            default: step = a;
        endcase
    endfunction

    function automatic logic [3:0] pick(input logic [7:0] req, input logic [2:0] start);
        logic [2:0] idx;
        pick = 4'h0;
        for (int k = 7; k >= 0; k--) begin
            idx = start + 3'(k);
            if (req[idx]) begin
                pick = {1'b1, idx};
            end
        end
    endfunction

    function automatic logic outside(input logic [15:0] a, input logic [15:0] hi, input logic [15:0] lo);
        outside = (a > SFR_TOP) && ((a > hi) || (a < lo));
    endfunction

    // ==================================================
    // State
    logic        eng_en, prio_rr, pd_low, pd_high;
    logic [15:0] hi_lim, lo_lim;
    logic [15:0] ctrl [8];
    logic [6:0]  tsel [8];
    logic [15:0] src [8], dst [8], cnt [8];
    logic [15:0] src0 [8], dst0 [8], cnt0 [8];
    logic [7:0]  f_hi, f_lo, f_done, f_ovr, pend, on;
    mdc_state_e  st;
    logic [2:0]  cur, last;
    logic [15:0] dbuf;

    // ==================================================
    // Register bus decode
    logic       wr, sw_req_wr;
    logic [2:0] wch;
    logic [4:0] woff;
    logic       glob;
    assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign wch  = wb_adr_i[7:5];
    assign woff = wb_adr_i[4:0];
    assign glob = !wb_adr_i[CH_SEL_BIT];
    assign sw_req_wr = wr && !glob && woff == CH_CTRL && wb_sel_i[1] && wb_dat_i[SWREQ_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= 32'h0000_0000;
            if (glob) begin
                unique case (wb_adr_i)
                    REG_ENGINE:   wb_dat_o[15:0] <= 16'(eng_en) << ENG_EN_BIT | 16'(prio_rr) << PRIO_BIT;
                    REG_HIGH_LIM: wb_dat_o[15:0] <= hi_lim;
                    REG_LOW_LIM:  wb_dat_o[15:0] <= lo_lim;
                    REG_PWRDN:    wb_dat_o[1:0]  <= {pd_high, pd_low};
                    default:      wb_dat_o       <= 32'h0000_0000;
                endcase
            end else begin
                unique case (woff)
                    CH_CTRL: wb_dat_o[15:0] <= ctrl[wch];
                    CH_INT:  wb_dat_o[15:0] <= {1'b0, tsel[wch], f_hi[wch], f_lo[wch], f_done[wch],
                                                1'b0, f_ovr[wch], 3'h0};
                    CH_SRC:  wb_dat_o[15:0] <= src[wch];
                    CH_DST:  wb_dat_o[15:0] <= dst[wch];
                    CH_CNT:  wb_dat_o[15:0] <= cnt[wch];
                    default: wb_dat_o       <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==================================================
    // Engine-level controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eng_en  <= 1'b0;
            prio_rr <= 1'b0;
            hi_lim  <= HIGH_LIM_RST;
            lo_lim  <= LOW_LIM_RST;
            pd_low  <= 1'b0;
            pd_high <= 1'b0;
        end else if (wr && glob) begin
            if (wb_adr_i == REG_ENGINE && wb_sel_i[1]) begin
                eng_en <= wb_dat_i[ENG_EN_BIT];
            end
            if (wb_adr_i == REG_ENGINE && wb_sel_i[0]) begin
                prio_rr <= wb_dat_i[PRIO_BIT];
            end
            if (wb_adr_i == REG_HIGH_LIM) begin
                hi_lim <= merge16(hi_lim, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == REG_LOW_LIM) begin
                lo_lim <= merge16(lo_lim, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == REG_PWRDN && wb_sel_i[0]) begin
                pd_low  <= wb_dat_i[PD_LOW_BIT];
                pd_high <= wb_dat_i[PD_HIGH_BIT];
            end
        end
    end

    // ==================================================
    // Channel availability, triggers and arbitration
    logic [7:0] hit, req, req_f, last_oh;
    logic [3:0] gnt;
    logic       cur_byte, issue, viol_s, viol_d;
    logic [1:0] cur_tr;
    logic [15:0] cnt_cur;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // Power-down groups gate half of the channels each
            on[i]  = eng_en && ctrl[i][CHANNEL_ENABLE_BIT] && !(i < 4 ? pd_low : pd_high);
            hit[i] = on[i] && ((tsel[i] != 7'h00 && trig_i[tsel[i]]) || (sw_req_wr && wch == 3'(i)));
        end
    end

    assign req     = pend & on;
    assign last_oh = 8'h01 << last;
    // The channel just served steps aside while any other one waits
    assign req_f   = ((req & ~last_oh) != 8'h00) ? (req & ~last_oh) : req;
    assign gnt     = prio_rr ? pick(req, last + 3'h1) : pick(req_f, 3'h0);
    assign issue   = st == ST_IDLE && gnt[3] && !cpu_bus_req_i;
    assign viol_s  = outside(src[gnt[2:0]], hi_lim, lo_lim);
    assign viol_d  = outside(dst[gnt[2:0]], hi_lim, lo_lim);
    assign cur_byte = ctrl[cur][SIZE_BIT];
    assign cur_tr   = ctrl[cur][TRM_LSB +: 2];
    assign cnt_cur  = cnt[cur];

    logic last_item, fin, abort;
    assign last_item = cnt_cur <= 16'h0001;
    assign fin   = st == ST_UPDATE && last_item;
    assign abort = issue && (viol_s || viol_d);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!on[i]) begin
                    pend[i] <= 1'b0;
                end else if (hit[i]) begin
                    pend[i] <= 1'b1;
                end else if (st == ST_UPDATE && cur == 3'(i) && (!cur_tr[1] || last_item)) begin
                    pend[i] <= 1'b0;
                end else if (abort && gnt[2:0] == 3'(i)) begin
                    pend[i] <= 1'b0;
                end
            end
        end
    end

    // ==================================================
    // Channel control, flags and trigger select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) begin
                ctrl[i] <= CTRL_RST;
                tsel[i] <= 7'h00;
            end
            f_hi   <= 8'h00;
            f_lo   <= 8'h00;
            f_done <= 8'h00;
            f_ovr  <= 8'h00;
        end else begin
            if (wr && !glob && woff == CH_CTRL) begin
                ctrl[wch] <= merge16(ctrl[wch], wb_dat_i, wb_sel_i) & CTRL_MASK;
            end
            if (wr && !glob && woff == CH_INT) begin
                if (wb_sel_i[1]) begin
                    tsel[wch] <= wb_dat_i[TSEL_LSB +: 7];
                end
                if (wb_sel_i[0]) begin
                    f_hi[wch]   <= wb_dat_i[HIGHF_BIT];
                    f_lo[wch]   <= wb_dat_i[LOWF_BIT];
                    f_done[wch] <= wb_dat_i[DONE_BIT];
                    f_ovr[wch]  <= wb_dat_i[OVR_BIT];
                end
            end
            // Hardware sets come last so they win over a clearing write
            for (int i = 0; i < 8; i++) begin
                if (hit[i] && pend[i]) begin
                    f_ovr[i] <= 1'b1;
                end
            end
            if (abort) begin
                // Limit flags are sticky: only software clears them
                if ((viol_s && src[gnt[2:0]] > hi_lim) || (viol_d && dst[gnt[2:0]] > hi_lim)) begin
                    f_hi[gnt[2:0]] <= 1'b1;
                end
                if ((viol_s && src[gnt[2:0]] < lo_lim) || (viol_d && dst[gnt[2:0]] < lo_lim)) begin
                    f_lo[gnt[2:0]] <= 1'b1;
                end
                ctrl[gnt[2:0]][CHANNEL_ENABLE_BIT] <= 1'b0;
            end
            if (fin) begin
                f_done[cur] <= 1'b1;
                if (!cur_tr[0]) begin
                    ctrl[cur][CHANNEL_ENABLE_BIT] <= 1'b0;
                end
            end
        end
    end

    // ==================================================
    // Pointers and counters with reload copies
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) begin
                src[i]  <= 16'h0000;
                dst[i]  <= 16'h0000;
                cnt[i]  <= 16'h0000;
                src0[i] <= 16'h0000;
                dst0[i] <= 16'h0000;
                cnt0[i] <= 16'h0000;
            end
        end else begin
            if (wr && !glob && woff == CH_SRC) begin
                src[wch]  <= merge16(src[wch], wb_dat_i, wb_sel_i);
                src0[wch] <= merge16(src[wch], wb_dat_i, wb_sel_i);
            end
            if (wr && !glob && woff == CH_DST) begin
                dst[wch]  <= merge16(dst[wch], wb_dat_i, wb_sel_i);
                dst0[wch] <= merge16(dst[wch], wb_dat_i, wb_sel_i);
            end
            if (wr && !glob && woff == CH_CNT) begin
                cnt[wch]  <= merge16(cnt[wch], wb_dat_i, wb_sel_i);
                cnt0[wch] <= merge16(cnt[wch], wb_dat_i, wb_sel_i);
            end
            if (st == ST_UPDATE) begin
                if (last_item && (cur_tr[0] || ctrl[cur][RELOAD_BIT])) begin
                    src[cur] <= src0[cur];
                    dst[cur] <= dst0[cur];
                    cnt[cur] <= cnt0[cur];
                end else begin
                    // Independent source and destination stepping
                    src[cur] <= step(src[cur], ctrl[cur][SAM_LSB +: 2], cur_byte);
                    dst[cur] <= step(dst[cur], ctrl[cur][DAM_LSB +: 2], cur_byte);
                    cnt[cur] <= last_item ? 16'h0000 : cnt_cur - 16'h0001;
                end
            end
        end
    end

    // ==================================================
    // Transfer engine and bus master
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st          <= ST_IDLE;
            cur         <= 3'h0;
            last        <= 3'h7;
            dbuf        <= 16'h0000;
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= 16'h0000;
            mem_wdata_o <= 16'h0000;
            mem_be_o    <= 2'h0;
        end else if (st != ST_IDLE && !on[cur]) begin
            // Disabling mid-move abandons the access in flight
            st        <= ST_IDLE;
            mem_req_o <= 1'b0;
        end else begin
            unique case (st)
                ST_IDLE: begin
                    if (issue) begin
                        cur  <= gnt[2:0];
                        last <= gnt[2:0];
                        if (!(viol_s || viol_d)) begin
                            st         <= ST_READ;
                            mem_req_o  <= 1'b1;
                            mem_we_o   <= 1'b0;
                            mem_addr_o <= src[gnt[2:0]];
                            mem_be_o   <= !ctrl[gnt[2:0]][SIZE_BIT] ? 2'h3 :
                                          (src[gnt[2:0]][0] ? 2'h2 : 2'h1);
                        end
                    end
                end
                ST_READ: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        st        <= ST_WRITE;
                        if (!cur_byte) begin
                            dbuf <= mem_rdata_i;
                        end else begin
                            dbuf <= {2{mem_addr_o[0] ? mem_rdata_i[15:8] : mem_rdata_i[7:0]}};
                        end
                    end
                end
                ST_WRITE: begin
                    if (mem_req_o && mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o  <= 1'b0;
                        st        <= ST_UPDATE;
                    end else if (!mem_req_o && !cpu_bus_req_i) begin
                        mem_req_o   <= 1'b1;
                        mem_we_o    <= 1'b1;
                        mem_addr_o  <= dst[cur];
                        mem_wdata_o <= dbuf;
                        mem_be_o    <= !cur_byte ? 2'h3 : (dst[cur][0] ? 2'h2 : 2'h1);
                    end
                end
                ST_UPDATE: begin
                    st <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan_event_o <= 8'h00;
        end else begin
            chan_event_o <= (abort ? 8'h01 << gnt[2:0] : 8'h00) | (fin ? 8'h01 << cur : 8'h00);
        end
    end

    // ==================================================
    // Assertions
    property p_yield;
        @(posedge clk_i) disable iff (rst_i) $rose(mem_req_o) |-> !$past(cpu_bus_req_i);
    endproperty
    a_yield: assert property (p_yield) else $error("bus taken while CPU asked for it");
    property p_limit;
        @(posedge clk_i) disable iff (rst_i) abort |=> !mem_req_o && chan_event_o != 8'h00 && st == ST_IDLE;
    endproperty
    a_limit: assert property (p_limit) else $error("limit violation not terminated");
    property p_word_be;
        @(posedge clk_i) disable iff (rst_i) mem_req_o && !cur_byte |-> mem_be_o == 2'h3;
    endproperty
    a_word_be: assert property (p_word_be) else $error("word move without both lanes");
    property p_byte_lane;
        @(posedge clk_i) disable iff (rst_i) mem_req_o && cur_byte |-> mem_be_o == (mem_addr_o[0] ? 2'h2 : 2'h1);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte lane does not follow address LSB");
    property p_disable;
        @(posedge clk_i) disable iff (rst_i) !eng_en ##1 !eng_en |-> st == ST_IDLE && !mem_req_o;
    endproperty
    a_disable: assert property (p_disable) else $error("engine active while disabled");
    property p_fixed;
        @(posedge clk_i) disable iff (rst_i) !prio_rr && req[0] && last != 3'h0 |-> gnt == 4'h8;
    endproperty
    a_fixed: assert property (p_fixed) else $error("lowest requester not granted");
    property p_rr_next;
        @(posedge clk_i) disable iff (rst_i) prio_rr && req[last + 3'h1] |-> gnt[2:0] == last + 3'h1;
    endproperty
    a_rr_next: assert property (p_rr_next) else $error("round-robin order broken");
    property p_no_retrig;
        @(posedge clk_i) disable iff (rst_i) !prio_rr && (req & ~last_oh) != 8'h00 |-> gnt[2:0] != last;
    endproperty
    a_no_retrig: assert property (p_no_retrig) else $error("served channel regranted at once");
    property p_cnt_dec;
        @(posedge clk_i) disable iff (rst_i)
            st == ST_UPDATE && on[cur] && cnt_cur > 16'h0001 |=> cnt_cur == $past(cnt_cur) - 16'h0001;
    endproperty
    a_cnt_dec: assert property (p_cnt_dec) else $error("count not decremented by one");

endmodule

// ### testbench/mdc_mem_model.sv
// Memory model answering the engine's bus master
`timescale 1ns/10ps
module mdc_mem_model (
    // Bus from the engine
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [1:0]  be_i,
    output      logic        ack_o,
    output      logic [15:0] rdata_o
);
    logic [15:0] mem [32768];
    logic [1:0]  waits = 2'h0;
    initial begin
        ack_o = 1'b0;
        rdata_o = 16'h0;
        for (int i = 0; i < 32768; i++) mem[i] = {i[7:0] ^ 8'h5a, i[7:0]};
    end
    // Address bit 13 set answers slowly; released data toggles so stale values fail
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            waits <= waits + 2'h1;
            if (waits >= {2{addr_i[13]}}) begin
                ack_o <= 1'b1;
                waits <= 2'h0;
                rdata_o <= mem[addr_i[15:1]];
                if (we_i && be_i[0]) mem[addr_i[15:1]][7:0] <= wdata_i[7:0];
                if (we_i && be_i[1]) mem[addr_i[15:1]][15:8] <= wdata_i[15:8];
            end
        end
    end
endmodule

// ### testbench/test_mdc_top.sv
// Self-checking bench for the eight-channel memory mover
`timescale 1ns/10ps
module test_mdc_top;
    logic         clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, cpu = 1'b0;
    logic [8:0]   adr = 9'h0;
    logic [15:0]  dat = 16'h0, mem_addr_o, mem_wdata_o, mem_rdata;
    logic [127:0] trig = '0;
    logic [31:0]  wb_dat_o;
    logic [7:0]   chan_event_o;
    logic [1:0]   mem_be_o;
    logic         wb_ack_o, mem_req_o, mem_we_o, mem_ack;
    int           miscompares = 0, cmp_count = 0, cycles = 0, ev_cnt [8] = '{default: 0};
    mdc_top i_mdc_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h3), .wb_dat_i({16'h0, dat}), .wb_dat_o, .wb_ack_o, .trig_i(trig), .cpu_bus_req_i(cpu),
        .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_be_o, .mem_ack_i(mem_ack),
        .mem_rdata_i(mem_rdata), .chan_event_o);
    mdc_mem_model i_mdc_mem_model (.clk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
        .wdata_i(mem_wdata_o), .be_i(mem_be_o), .ack_o(mem_ack), .rdata_o(mem_rdata));
    initial forever #2.5 clk_i = ~clk_i;
    // Pulses are counted so one landing inside a bus cycle is not lost
    always @(posedge clk_i) begin
        cycles++;
        for (int n = 0; n < 8; n++) if (chan_event_o[n] === 1'b1) ev_cnt[n]++;
        if (cycles == 5000) begin
            miscompares++;
            test_done;
        end
    end
    function automatic logic [15:0] pat(input int w);
        return {w[7:0] ^ 8'h5a, w[7:0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [8:0] a, input logic [15:0] d, input logic [15:0] e);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        if (!w) chk(wb_dat_o[15:0], e);
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        logic [15:0] q;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, 9'h004, 0, 16'hffff);
        wb(0, 9'h100, 0, 16'h0000);
        wb(1, 9'h000, 16'h8000, 0);
        wb(1, 9'h108, 16'h1000, 0);
        wb(1, 9'h10c, 16'h2000, 0);
        wb(1, 9'h110, 16'h0003, 0);
        wb(1, 9'h100, 16'h0059, 0);
        cpu <= 1'b1;
        wb(1, 9'h100, 16'h0159, 0);
        repeat (10) @(posedge clk_i);
        chk({15'h0, mem_req_o}, 16'h0);
        cpu <= 1'b0;
        while (ev_cnt[0] == 0) @(posedge clk_i);
        for (int i = 0; i < 3; i++) chk(i_mdc_mem_model.mem[16'h1000 + i], pat(16'h800 + i));
        wb(0, 9'h108, 0, 16'h1006);
        wb(0, 9'h104, 0, 16'h0020);
        // Byte one-shot with reload, upper source lane, trigger line 5
        wb(1, 9'h128, 16'h1023, 0);
        wb(1, 9'h12c, 16'h3000, 0);
        wb(1, 9'h130, 16'h0001, 0);
        wb(1, 9'h120, 16'h0203, 0);
        wb(1, 9'h124, 16'h0500, 0);
        trig[5] <= 1'b1;
        @(posedge clk_i);
        trig[5] <= 1'b0;
        while (ev_cnt[1] == 0) @(posedge clk_i);
        q = pat(16'h811);
        chk(i_mdc_mem_model.mem[16'h1800], (pat(16'h1800) & 16'hff00) | (q >> 8));
        wb(0, 9'h130, 0, 16'h0001);
        wb(0, 9'h120, 0, 16'h0202);
        // Source under the low limit must abort without any access
        wb(1, 9'h008, 16'h4000, 0);
        wb(1, 9'h148, 16'h1000, 0);
        wb(1, 9'h14c, 16'h5000, 0);
        wb(1, 9'h140, 16'h0001, 0);
        wb(1, 9'h140, 16'h0101, 0);
        while (ev_cnt[2] == 0) @(posedge clk_i);
        wb(0, 9'h144, 0, 16'h0040);
        chk(i_mdc_mem_model.mem[16'h2800], pat(16'h2800));
        // Round robin after channel 2: channel 3 goes before channel 0, so channel 0 writes last
        wb(1, 9'h000, 16'h8001, 0);
        wb(1, 9'h108, 16'h4100, 0);
        wb(1, 9'h10c, 16'h4300, 0);
        wb(1, 9'h100, 16'h0001, 0);
        wb(1, 9'h104, 16'h0600, 0);
        wb(1, 9'h168, 16'h4200, 0);
        wb(1, 9'h16c, 16'h4300, 0);
        wb(1, 9'h160, 16'h0001, 0);
        wb(1, 9'h164, 16'h0600, 0);
        trig[6] <= 1'b1;
        @(posedge clk_i);
        trig[6] <= 1'b0;
        while (ev_cnt[0] < 2 || ev_cnt[3] == 0) @(posedge clk_i);
        chk(i_mdc_mem_model.mem[16'h2180], pat(16'h2080));
        test_done;
    end
endmodule
